// >>> rtl/two_wire_pkg.sv
// constants, register map and state encodings of the two-wire control port
// How it works
// - first byte: seven address bits, then direction
// - direction one reads, zero writes
// - matching address: pull data low on ninth
// - other address: stay released, no acknowledge
// - lowest address bit comes from select pin
// - bytes travel most significant bit first
// - data moves only while clock low
// - start: data falls while clock high
// - stop: data rises while clock high
// - start without stop is a repeated start
// - byte after address sets register pointer
// - write data lands at pointer, pointer advances
// - read starts at pointer, advances per byte
// - write to an unmapped offset is acknowledged, not stored
// - master nack ends read, line released
// - 0x16 bit 7 adds PLL divide-by-two
// - 0x16 bits 6-5 pick sync-on-green bandwidth
// - 0x16 bit 4 picks analog input bandwidth
// - 0x19-0x1b colour offset targets, reset four
// - 0x1d bit 7 enables auto-offset, reset zero
// - 0x1d bit 6 holds auto-offset, reset zero
// - 0x1d bits 1-0 update rate, reset 10
package two_wire_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         SYS_PERIOD_NS = 100;
    localparam int         QUARTER_NS    = 300;
    localparam int         QUARTER_CYC   =
        (QUARTER_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [1:0] QUARTER_LAST  = 2'(QUARTER_CYC - 1);
    localparam logic [3:0] BYTE_BITS     = 4'h8;

    // ------------------------------------------------------------
    // device register map
    // ------------------------------------------------------------
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h26;
    localparam int         NUM_REGS      = 5;
    localparam int         IDX_PLL       = 0;
    localparam int         IDX_RED       = 1;
    localparam int         IDX_GREEN     = 2;
    localparam int         IDX_BLUE      = 3;
    localparam int         IDX_AOFS      = 4;
    localparam logic [NUM_REGS-1:0][7:0] REG_OFFSET =
        {8'h1d, 8'h1b, 8'h1a, 8'h19, 8'h16};
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET  =
        {8'h02, 8'h04, 8'h04, 8'h04, 8'h00};
    localparam int PLL_DIV_BIT = 7;
    localparam int SOG_BW_HI   = 6;
    localparam int SOG_BW_LO   = 5;
    localparam int AIN_BW_BIT  = 4;
    localparam int AO_EN_BIT   = 7;
    localparam int AO_HOLD_BIT = 6;
    localparam int AO_RATE_HI  = 1;
    localparam int AO_RATE_LO  = 0;

    // ------------------------------------------------------------
    // controller registers
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OFS   = 8'h00;
    localparam logic [7:0] TX_OFS    = 8'h04;
    localparam logic [7:0] STAT_OFS  = 8'h08;
    localparam int         CMD_START = 0;
    localparam int         CMD_STOP  = 1;
    localparam int         CMD_XFER  = 2;
    localparam int         CMD_READ  = 3;
    localparam int         CMD_NACK  = 4;

    typedef enum logic [2:0] {
        D_IDLE = 3'h0, D_RECV = 3'h1, D_SACK = 3'h3,
        D_SEND = 3'h2, D_MACK = 3'h6
    } dev_state_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h3, H_STOP = 2'h2
    } host_state_t;
endpackage

// >>> rtl/two_wire_if.sv
// open-drain two-wire bus joining the controller and the device
`timescale 1ns/1ps
interface two_wire_if;
    logic hostSclOut;
    logic hostSclDriveN;
    logic hostSdaOut;
    logic hostSdaDriveN;
    logic devSdaOut;
    logic devSdaDriveN;
    wire  scl;
    wire  sda;

    // pull-ups win unless a driver pulls low
    assign scl = hostSclDriveN | hostSclOut;
    assign sda = (hostSdaDriveN | hostSdaOut) & (devSdaDriveN | devSdaOut);

    modport device (input scl, input sda,
                    output devSdaOut, output devSdaDriveN);
    modport host (input sda, input scl,
                  output hostSclOut, output hostSclDriveN,
                  output hostSdaOut, output hostSdaDriveN);
endinterface

// >>> rtl/sync_2ff.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // pins
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // idle bus level is high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q  <= '1;
            syncOut <= '1;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// >>> rtl/two_wire_device.sv
// two-wire slave port with its configuration registers
`timescale 1ns/1ps
module two_wire_device (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // bus
    two_wire_if.device        bus,
    // strap
    input  wire logic         addressSelectPins,
    // pll and input filters
    output logic              extraPllDivide,
    output logic [1:0]        syncOnGreenInputBw,
    output logic              analogInputBw,
    // auto-offset
    output logic [7:0]        redOffsetTarget,
    output logic [7:0]        greenOffsetTarget,
    output logic [7:0]        blueOffsetTarget,
    output logic              autoOffsetEnable,
    output logic              autoOffsetHold,
    output logic [1:0]        autoOffsetRate
);
    import two_wire_pkg::*;

    // ------------------------------------------------------------
    // pin sampling and bus conditions
    // ------------------------------------------------------------
    logic [2:0] pinSync;
    logic       sclP_q;
    logic       sdaP_q;

    sync_2ff #(.WIDTH(3)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn ({bus.scl, bus.sda, addressSelectPins}),
        .syncOut (pinSync)
    );

    wire sclS     = pinSync[2];
    wire sdaS     = pinSync[1];
    wire addrSelS = pinSync[0];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
        end else begin
            sclP_q <= sclS;
            sdaP_q <= sdaS;
        end
    end

    wire sclRise = sclS & ~sclP_q;
    wire sclFall = ~sclS & sclP_q;
    // data edges under a high clock frame the transfer
    wire startSeen = sclS & sclP_q & sdaP_q & ~sdaS;
    wire stopSeen  = sclS & sclP_q & ~sdaP_q & sdaS;

    // ------------------------------------------------------------
    // register pointer decode
    // ------------------------------------------------------------
    function automatic logic [3:0] findReg(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (REG_OFFSET[i] == a) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    dev_state_t state_q;
    dev_state_t state_d;
    logic [3:0] bitCnt_q;
    logic [3:0] bitCnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [1:0] byteIdx_q;
    logic [1:0] byteIdx_d;
    logic       readMode_q;
    logic       readMode_d;
    logic       sdaLow_q;
    logic       sdaLow_d;
    logic [7:0] regs_q [NUM_REGS];

    wire [3:0] ptrHit   = findReg(ptr_q);
    wire [7:0] readByte = ptrHit[3] ? regs_q[ptrHit[2:0]] : 8'h00;
    wire       byteDone = bitCnt_q == BYTE_BITS;
    // lowest address bit is the strap, so two parts share a bus
    wire addrMatch = shift_q[7:1] == {SLAVE_ADDR_HI, addrSelS};
    wire dataByte  = byteIdx_q == 2'h2;
    wire regWrite  = (state_q == D_RECV) & sclFall & byteDone
                   & dataByte & ptrHit[3] & ~stopSeen & ~startSeen;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // offsets with no register accept the byte silently
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                regs_q[g] <= REG_RESET[g];
            end else if (regWrite && ptrHit[2:0] == 3'(g)) begin
                regs_q[g] <= shift_q;
            end
        end
    end

    assign extraPllDivide     = regs_q[IDX_PLL][PLL_DIV_BIT];
    assign syncOnGreenInputBw =
        regs_q[IDX_PLL][SOG_BW_HI:SOG_BW_LO];
    assign analogInputBw      = regs_q[IDX_PLL][AIN_BW_BIT];
    assign redOffsetTarget    = regs_q[IDX_RED];
    assign greenOffsetTarget  = regs_q[IDX_GREEN];
    assign blueOffsetTarget   = regs_q[IDX_BLUE];
    assign autoOffsetEnable   = regs_q[IDX_AOFS][AO_EN_BIT];
    assign autoOffsetHold     = regs_q[IDX_AOFS][AO_HOLD_BIT];
    assign autoOffsetRate     =
        regs_q[IDX_AOFS][AO_RATE_HI:AO_RATE_LO];

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        bitCnt_d   = bitCnt_q;
        shift_d    = shift_q;
        ptr_d      = ptr_q;
        byteIdx_d  = byteIdx_q;
        readMode_d = readMode_q;
        sdaLow_d   = sdaLow_q;
        if (stopSeen) begin
            state_d  = D_IDLE;
            sdaLow_d = 1'b0;
        end else if (startSeen) begin
            // honoured in any state, so repeated starts need no stop
            state_d   = D_RECV;
            bitCnt_d  = 4'h0;
            byteIdx_d = 2'h0;
            sdaLow_d  = 1'b0;
        end else begin
            case (state_q)
                D_RECV: begin
                    if (sclRise && !byteDone) begin
                        shift_d  = {shift_q[6:0], sdaS};
                        bitCnt_d = 4'(bitCnt_q + 4'h1);
                    end else if (sclFall && byteDone) begin
                        if (byteIdx_q == 2'h0 && !addrMatch) begin
                            state_d = D_IDLE;
                        end else begin
                            state_d  = D_SACK;
                            sdaLow_d = 1'b1;
                        end
                        if (byteIdx_q == 2'h0) begin
                            readMode_d = shift_q[0];
                        end
                        if (byteIdx_q == 2'h1) begin
                            ptr_d = shift_q;
                        end
                        if (dataByte) begin
                            ptr_d = 8'(ptr_q + 8'h01);
                        end else begin
                            byteIdx_d = 2'(byteIdx_q + 2'h1);
                        end
                    end
                end
                D_SACK: begin
                    if (sclFall) begin
                        bitCnt_d = 4'h0;
                        if (readMode_q) begin
                            state_d  = D_SEND;
                            shift_d  = readByte;
                            sdaLow_d = ~readByte[7];
                        end else begin
                            state_d  = D_RECV;
                            sdaLow_d = 1'b0;
                        end
                    end
                end
                D_SEND: begin
                    // new bit only after the clock fell
                    if (sclRise) begin
                        bitCnt_d = 4'(bitCnt_q + 4'h1);
                    end else if (sclFall && byteDone) begin
                        state_d  = D_MACK;
                        sdaLow_d = 1'b0;
                        ptr_d    = 8'(ptr_q + 8'h01);
                    end else if (sclFall) begin
                        shift_d  = {shift_q[6:0], 1'b0};
                        sdaLow_d = ~shift_q[6];
                    end
                end
                D_MACK: begin
                    if (sclRise && sdaS) begin
                        state_d = D_IDLE;
                    end else if (sclFall) begin
                        state_d  = D_SEND;
                        bitCnt_d = 4'h0;
                        shift_d  = readByte;
                        sdaLow_d = ~readByte[7];
                    end
                end
                default: begin
                    state_d  = D_IDLE;
                    sdaLow_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q    <= D_IDLE;
            bitCnt_q   <= 4'h0;
            shift_q    <= 8'h00;
            ptr_q      <= 8'h00;
            byteIdx_q  <= 2'h0;
            readMode_q <= 1'b0;
            sdaLow_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            bitCnt_q   <= bitCnt_d;
            shift_q    <= shift_d;
            ptr_q      <= ptr_d;
            byteIdx_q  <= byteIdx_d;
            readMode_q <= readMode_d;
            sdaLow_q   <= sdaLow_d;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // open drain: only ever pulls low
    assign bus.devSdaOut    = ~sdaLow_q;
    assign bus.devSdaDriveN = ~sdaLow_q;
endmodule

// >>> rtl/two_wire_host.sv
// two-wire bus master driven by software over apb
`timescale 1ns/1ps
module two_wire_host (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // bus
    two_wire_if.host          bus,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr
);
    import two_wire_pkg::*;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    host_state_t state_q;
    host_state_t state_d;
    logic [4:0]  cmd_q;
    logic [4:0]  cmd_d;
    logic [7:0]  tx_q;
    logic [1:0]  div_q;
    logic [1:0]  qPh_q;
    logic [1:0]  qPh_d;
    logic [3:0]  bitCnt_q;
    logic [3:0]  bitCnt_d;
    logic [8:0]  outSh_q;
    logic [8:0]  outSh_d;
    logic [8:0]  inSh_q;
    logic [8:0]  inSh_d;
    logic        nack_q;
    logic        nack_d;
    logic        sclLow_q;
    logic        sdaLow_q;
    logic        sdaS;

    wire busy    = state_q != H_IDLE;
    wire access  = psel & penable;
    wire hitCmd  = paddr == CMD_OFS;
    wire hitTx   = paddr == TX_OFS;
    wire hitStat = paddr == STAT_OFS;
    wire wrCmd   = access & pwrite & hitCmd;
    // commands while busy are dropped; poll busy first
    wire accept  = wrCmd & ~busy;
    wire [31:0] rdMux = hitCmd  ? {27'h0, cmd_q} :
                        hitTx   ? {24'h0, tx_q} :
                        hitStat ? {16'h0, inSh_q[8:1], 6'h0, nack_q, busy}
                                : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = access & ~(hitCmd | hitTx | hitStat);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0;
            tx_q   <= 8'h00;
        end else begin
            if (psel && !penable) begin
                prdata <= rdMux;
            end
            if (access && pwrite && hitTx) begin
                tx_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // quarter-bit timing
    // ------------------------------------------------------------
    sync_2ff #(.WIDTH(1)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (bus.sda),
        .syncOut (sdaS)
    );

    wire tick     = busy & (div_q == QUARTER_LAST);
    wire phaseEnd = tick & (qPh_q == 2'h3);

    always_ff @(posedge sys_clk) begin
        if (rst || !busy || tick) begin
            div_q <= 2'h0;
        end else begin
            div_q <= 2'(div_q + 2'h1);
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        cmd_d    = cmd_q;
        qPh_d    = tick ? 2'(qPh_q + 2'h1) : qPh_q;
        bitCnt_d = bitCnt_q;
        outSh_d  = outSh_q;
        inSh_d   = inSh_q;
        nack_d   = nack_q;
        case (state_q)
            H_IDLE: begin
                qPh_d = 2'h0;
                if (accept) begin
                    cmd_d    = pwdata[4:0];
                    bitCnt_d = 4'h0;
                    outSh_d  = pwdata[CMD_READ] ?
                               {8'hff, pwdata[CMD_NACK]} : {tx_q, 1'b1};
                    state_d  = pwdata[CMD_START] ? H_START :
                               pwdata[CMD_XFER]  ? H_BIT :
                               pwdata[CMD_STOP]  ? H_STOP : H_IDLE;
                end
            end
            H_START: begin
                if (phaseEnd) begin
                    state_d = cmd_q[CMD_XFER] ? H_BIT :
                              cmd_q[CMD_STOP] ? H_STOP : H_IDLE;
                end
            end
            H_BIT: begin
                if (phaseEnd) begin
                    inSh_d   = {inSh_q[7:0], sdaS};
                    outSh_d  = {outSh_q[7:0], 1'b1};
                    bitCnt_d = 4'(bitCnt_q + 4'h1);
                    if (bitCnt_q == BYTE_BITS) begin
                        nack_d  = sdaS;
                        state_d = cmd_q[CMD_STOP] ? H_STOP : H_IDLE;
                    end
                end
            end
            H_STOP: begin
                if (phaseEnd) begin
                    state_d = H_IDLE;
                end
            end
            default: state_d = H_IDLE;
        endcase
    end

    // clock low in quarters 0-1, high in 2-3; data moves from quarter 1
    wire sclLow_d = (state_d != H_IDLE) ? (qPh_d < 2'h2) : sclLow_q;
    wire sdaLow_d = (state_d == H_IDLE || qPh_d == 2'h0) ? sdaLow_q :
                    (state_d == H_START) ? (qPh_d == 2'h3) :
                    (state_d == H_STOP)  ? (qPh_d != 2'h3) :
                    ~outSh_d[8];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q  <= H_IDLE;
            cmd_q    <= 5'h00;
            qPh_q    <= 2'h0;
            bitCnt_q <= 4'h0;
            outSh_q  <= 9'h1ff;
            inSh_q   <= 9'h000;
            nack_q   <= 1'b0;
            sclLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            cmd_q    <= cmd_d;
            qPh_q    <= qPh_d;
            bitCnt_q <= bitCnt_d;
            outSh_q  <= outSh_d;
            inSh_q   <= inSh_d;
            nack_q   <= nack_d;
            sclLow_q <= sclLow_d;
            sdaLow_q <= sdaLow_d;
        end
    end

    assign bus.hostSclOut    = ~sclLow_q;
    assign bus.hostSclDriveN = ~sclLow_q;
    assign bus.hostSdaOut    = ~sdaLow_q;
    assign bus.hostSdaDriveN = ~sdaLow_q;
endmodule

// >>> tb/two_wire_checker.sv
// wire-level assertions on the two-wire bus between both ends
`timescale 1ns/1ps
module two_wire_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus
    input wire logic scl,
    input wire logic sda,
    input wire logic hostSdaOut,
    input wire logic hostSdaDriveN,
    input wire logic devSdaOut,
    input wire logic devSdaDriveN
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // device side
    // ------------------------------------------------------------
    dev_edge_low_a: assert property (
        !$stable(devSdaDriveN) |-> !scl)
        else $error("device moved sda while scl high");
    dev_ack_hold_a: assert property (
        $fell(devSdaDriveN) |-> !devSdaDriveN [*8])
        else $error("device low pulse too short");
    dev_release_a: assert property (
        $fell(devSdaDriveN) |-> ##[1:120] devSdaDriveN)
        else $error("device kept sda low too long");
    dev_low_only_a: assert property (
        !devSdaDriveN |-> !devSdaOut)
        else $error("device drove sda high");
    // ------------------------------------------------------------
    // controller side and framing
    // ------------------------------------------------------------
    host_low_only_a: assert property (
        !hostSdaDriveN |-> !hostSdaOut)
        else $error("controller drove sda high");
    scl_low_span_a: assert property (
        $fell(scl) |-> !scl [*6] ##1 scl)
        else $error("scl low phase not six cycles");
    start_quiet_a: assert property (
        scl && $past(scl) && $fell(sda) |=> devSdaDriveN [*8])
        else $error("device drove sda right after start");
    stop_quiet_a: assert property (
        scl && $past(scl) && $rose(sda) |=> devSdaDriveN [*8])
        else $error("device drove sda right after stop");
endmodule

// >>> tb/testbench.sv
// self-checking bench: controller and device joined over the two-wire bus
`timescale 1ns/1ps
module testbench;
    import two_wire_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        addrSel   = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pllDiv;
    logic        ainBw;
    logic        aoEn;
    logic        aoHold;
    logic [1:0]  sogBw;
    logic [1:0]  aoRate;
    logic [7:0]  redT;
    logic [7:0]  grnT;
    logic [7:0]  bluT;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  gotByte;
    logic [7:0]  expQ[$];
    logic [7:0]  wb[8];
    logic [7:0]  eb[8];
    event        byteEv;
    int          n_fail    = 0;
    int          cmp_count = 0;
    two_wire_if  bus ();

    two_wire_device i_two_wire_device (.sys_clk(sys_clk), .rst(rst),
        .bus(bus), .addressSelectPins(addrSel), .extraPllDivide(pllDiv),
        .syncOnGreenInputBw(sogBw), .analogInputBw(ainBw),
        .redOffsetTarget(redT), .greenOffsetTarget(grnT),
        .blueOffsetTarget(bluT), .autoOffsetEnable(aoEn),
        .autoOffsetHold(aoHold), .autoOffsetRate(aoRate));
    two_wire_host i_two_wire_host (.sys_clk(sys_clk), .rst(rst),
        .bus(bus), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    two_wire_checker i_two_wire_checker (.sys_clk(sys_clk), .rst(rst),
        .scl(bus.scl), .sda(bus.sda), .hostSdaOut(bus.hostSdaOut),
        .hostSdaDriveN(bus.hostSdaDriveN), .devSdaOut(bus.devSdaOut),
        .devSdaDriveN(bus.devSdaDriveN));

    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // idle cycle at the end keeps back-to-back calls off one time step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic cmd(input logic [4:0] c, input logic [7:0] tx);
        apb(1'b1, TX_OFS, {24'h0, tx});
        apb(1'b1, CMD_OFS, {27'h0, c});
        do apb(1'b0, STAT_OFS, 32'h0); while (rd[0] !== 1'b0);
    endtask

    task automatic reset_check;
        chk("pll cfg", {pllDiv, sogBw, ainBw}, 4'h0);
        chk("targets", {redT, grnT, bluT}, 24'h040404);
        chk("aofs", {aoEn, aoHold, aoRate}, 4'h2);
    endtask

    always @(byteEv) chk("read byte", gotByte, expQ.pop_front());

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h2c32));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_check();
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped apb", {err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 4; i++) begin
            addrSel <= i[0];
            repeat (3) @(posedge sys_clk);
            cmd(5'h05, {SLAVE_ADDR_HI, ~i[0], 1'b0});
            chk("foreign nack", rd[1], 1'b1);
            cmd(5'h02, 8'h00);
            for (int k = 0; k < 8; k++) begin
                wb[k] = 8'($urandom);
            end
            wb[0] = {1'($urandom), i[1:0], 1'($urandom), 4'h0};
            wb[7] = {2'($urandom), 4'h0, i[1:0]};
            // 0x17, 0x18 and 0x1c are holes: written, never stored
            for (int k = 0; k < 8; k++) begin
                eb[k] = (k == 1 || k == 2 || k == 6) ? 8'h00 : wb[k];
            end
            cmd(5'h05, {SLAVE_ADDR_HI, i[0], 1'b0});
            chk("own ack", rd[1], 1'b0);
            cmd(5'h04, 8'h16);
            for (int k = 0; k < 8; k++) begin
                cmd((k == 7) ? 5'h06 : 5'h04, wb[k]);
                chk("data ack", rd[1], 1'b0);
            end
            chk("pll cfg", {pllDiv, sogBw, ainBw}, eb[0][7:4]);
            chk("targets", {redT, grnT, bluT}, {eb[3], eb[4], eb[5]});
            chk("aofs", {aoEn, aoHold, aoRate}, {eb[7][7:6], eb[7][1:0]});
            cmd(5'h05, {SLAVE_ADDR_HI, i[0], 1'b0});
            cmd(5'h04, 8'h16);
            cmd(5'h05, {SLAVE_ADDR_HI, i[0], 1'b1});
            chk("read ack", rd[1], 1'b0);
            for (int k = 0; k < 8; k++) begin
                expQ.push_back(eb[k]);
                cmd((k == 7) ? 5'h1e : 5'h0c, 8'h00);
                gotByte = rd[15:8];
                ->byteEv;
            end
        end
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_check();
        give_verdict();
    end
endmodule
